// ---- common/string_ops_pkg.sv ----
// Package with types and constants for the byte string operation engine.
package string_ops_pkg;

  typedef enum logic [2:0] {
    fill_block_op,
    copy_block_op,
    swap_accum_mem_op,
    swap_block_op,
    scan_equal_op
  } op_t;

  typedef struct packed {
    logic sign;
    logic zero;
    logic nibble_borrow_flag;
    logic overflow;
    logic borrow_flag;
  } flags_t;

  typedef struct packed {
    logic [15:0] target_pointer;
    logic [15:0] source_pointer;
    logic [7:0] count;
    logic [7:0] accum;
  } regs_t;

  typedef struct packed {
    logic req;
    logic wr;
    logic [15:0] addr;
    logic [7:0] wdata;
  } mem_req_t;

  localparam logic [15:0] POINTER_STEP = 16'h0001;
  localparam logic [7:0] COUNT_STEP = 8'h01;
  localparam logic [7:0] COUNT_DONE = 8'h00;
  localparam int SIGN_BIT = 7;
  localparam int NIBBLE_BIT = 4;
  localparam int OVF_BIT = 6;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [15:0] RESET_WORD = 16'h0000;

endpackage

// ---- src/byte_compare.sv ----
// Byte subtraction with full string compare flag generation.
`timescale 1ns/1ps
module byte_compare (
  input wire logic [7:0] minuend,
  input wire logic [7:0] subtrahend,
  output string_ops_pkg::flags_t flags
);
  logic [8:0] borrow;
  logic [7:0] diff;

  // Ripple borrow chain so the borrow out of every bit is visible.
  assign borrow[0] = 1'b0;
  genvar i;
  generate
    for (i = 0; i < 8; i++) begin : g_bit
      assign diff[i] = minuend[i] ^ subtrahend[i] ^ borrow[i];
      assign borrow[i + 1] = (~minuend[i] & (subtrahend[i] | borrow[i])) | (subtrahend[i] & borrow[i]);
    end
  endgenerate

  assign flags.sign = diff[string_ops_pkg::SIGN_BIT];
  assign flags.zero = (diff == string_ops_pkg::RESET_BYTE);
  assign flags.nibble_borrow_flag = borrow[string_ops_pkg::NIBBLE_BIT];
  // Borrow out of bit 6 against borrow out of bit 7.
  assign flags.overflow = borrow[string_ops_pkg::OVF_BIT + 1] ^ borrow[string_ops_pkg::SIGN_BIT + 1];
  assign flags.borrow_flag = borrow[string_ops_pkg::SIGN_BIT + 1];
endmodule

// ---- src/block_string_ops.sv ----
// Sequencer for fill, copy, swap and equal-scan string operations over the core memory bus.
`timescale 1ns/1ps
module block_string_ops (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire string_ops_pkg::op_t op,
  input wire logic descend,
  input wire string_ops_pkg::regs_t regs_in,
  input wire string_ops_pkg::flags_t flags_in,
  input wire logic break_req,
  input wire logic mem_ready,
  input wire logic [7:0] mem_rdata,
  output string_ops_pkg::mem_req_t mem,
  output logic busy,
  output logic done,
  output logic break_ack,
  output string_ops_pkg::regs_t regs_out,
  output string_ops_pkg::flags_t flags_out
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle,
    st_read_src,
    st_read_tgt,
    st_write_tgt,
    st_write_src,
    st_step
  } phase_t;

  typedef struct packed {
    phase_t phase;
    string_ops_pkg::op_t op;
    logic descend;
    string_ops_pkg::regs_t regs;
    string_ops_pkg::flags_t flags;
    // Bytes in flight between the read and write halves of one step.
    logic [7:0] src_byte;
    logic [7:0] tgt_byte;
    logic done;
    logic break_ack;
  } state_t;

  // ----------------------------------------------------------------
  // Operation decode
  // ----------------------------------------------------------------
  // Gives the first bus phase of a byte; an undefined code maps to idle so it never starts.
  function automatic phase_t first_phase(input string_ops_pkg::op_t code);
    phase_t ph;
    unique case (code)
      string_ops_pkg::fill_block_op: begin
        ph = st_write_tgt;
      end
      string_ops_pkg::copy_block_op: begin
        ph = st_read_src;
      end
      string_ops_pkg::swap_block_op: begin
        ph = st_read_src;
      end
      string_ops_pkg::swap_accum_mem_op: begin
        ph = st_read_tgt;
      end
      string_ops_pkg::scan_equal_op: begin
        ph = st_read_tgt;
      end
      default: begin
        ph = st_idle;
      end
    endcase
    return ph;
  endfunction

  state_t cur;
  state_t next_cur;
  string_ops_pkg::flags_t cmp_flags;
  logic [15:0] step_tgt;
  logic [15:0] step_src;
  logic [7:0] next_count;
  logic uses_source;

  byte_compare u_cmp (
    .minuend(cur.tgt_byte),
    .subtrahend(cur.regs.accum),
    .flags(cmp_flags)
  );

  assign step_tgt = cur.descend ? cur.regs.target_pointer - string_ops_pkg::POINTER_STEP
                                : cur.regs.target_pointer + string_ops_pkg::POINTER_STEP;
  assign step_src = cur.descend ? cur.regs.source_pointer - string_ops_pkg::POINTER_STEP
                                : cur.regs.source_pointer + string_ops_pkg::POINTER_STEP;
  // Count drops before its test, so zero on entry runs 256 bytes.
  assign next_count = cur.regs.count - string_ops_pkg::COUNT_STEP;
  // Copy and block swap walk a second pointer; the other operations leave it alone.
  assign uses_source = (cur.op == string_ops_pkg::copy_block_op || cur.op == string_ops_pkg::swap_block_op);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_cur = cur;
    next_cur.done = 1'b0;
    next_cur.break_ack = 1'b0;
    unique case (cur.phase)
      st_idle: begin
        // A resumed operation re-enters here with the same pointers and count.
        // An undefined operation code is refused and leaves every register as it was.
        if (start && first_phase(op) != st_idle) begin
          next_cur.op = op;
          next_cur.descend = descend;
          next_cur.regs = regs_in;
          next_cur.flags = flags_in;
          next_cur.phase = first_phase(op);
        end
      end
      st_read_src: begin
        if (mem_ready) begin
          next_cur.src_byte = mem_rdata;
          next_cur.phase = (cur.op == string_ops_pkg::swap_block_op) ? st_read_tgt : st_write_tgt;
        end
      end
      st_read_tgt: begin
        if (mem_ready) begin
          next_cur.tgt_byte = mem_rdata;
          // Equal scan only reads memory and never writes it back.
          next_cur.phase = (cur.op == string_ops_pkg::scan_equal_op) ? st_step : st_write_tgt;
        end
      end
      st_write_tgt: begin
        if (mem_ready) begin
          next_cur.phase = (cur.op == string_ops_pkg::swap_block_op) ? st_write_src : st_step;
          // The accumulator takes the old byte only once its own value has been written.
          if (cur.op == string_ops_pkg::swap_accum_mem_op) begin
            next_cur.regs.accum = cur.tgt_byte;
          end
        end
      end
      st_write_src: begin
        if (mem_ready) begin
          next_cur.phase = st_step;
        end
      end
      st_step: begin
        next_cur.regs.target_pointer = step_tgt;
        if (uses_source) begin
          next_cur.regs.source_pointer = step_src;
        end
        next_cur.regs.count = next_count;
        // Only the scan touches flags, and each step overwrites them all.
        if (cur.op == string_ops_pkg::scan_equal_op) begin
          next_cur.flags = cmp_flags;
        end
        // A finishing byte wins over a suspend request, so no empty resume is ever needed.
        if (next_count == string_ops_pkg::COUNT_DONE
            || (cur.op == string_ops_pkg::scan_equal_op && !cmp_flags.zero)) begin
          next_cur.phase = st_idle;
          next_cur.done = 1'b1;
        end else if (break_req) begin
          // Suspend between bytes with every register consistent for resume.
          next_cur.phase = st_idle;
          next_cur.break_ack = 1'b1;
        end else begin
          next_cur.phase = first_phase(cur.op);
        end
      end
      default: begin
        next_cur.phase = st_idle;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      cur <= '0;
    end else begin
      cur <= next_cur;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // The request follows the phase register only, so it stands unchanged until the memory answers.
  always_comb begin
    mem.req = 1'b0;
    mem.wr = 1'b0;
    mem.addr = cur.regs.target_pointer;
    mem.wdata = cur.regs.accum;
    unique case (cur.phase)
      st_read_src: begin
        mem.req = 1'b1;
        mem.addr = cur.regs.source_pointer;
      end
      st_read_tgt: begin
        mem.req = 1'b1;
      end
      st_write_tgt: begin
        mem.req = 1'b1;
        mem.wr = 1'b1;
        if (uses_source) begin
          mem.wdata = cur.src_byte;
        end
      end
      st_write_src: begin
        mem.req = 1'b1;
        mem.wr = 1'b1;
        mem.addr = cur.regs.source_pointer;
        mem.wdata = cur.tgt_byte;
      end
      default: begin
        mem.req = 1'b0;
      end
    endcase
  end

  assign busy = (cur.phase != st_idle);
  assign done = cur.done;
  assign break_ack = cur.break_ack;
  assign regs_out = cur.regs;
  assign flags_out = cur.flags;

endmodule

// ---- sim/mem_model.sv ----
// Byte memory model that answers the string engine's bus.
`timescale 1ns/1ps
module mem_model (
  input wire logic ref_clk,
  input wire logic slow,
  input wire string_ops_pkg::mem_req_t mem,
  output logic mem_ready,
  output logic [7:0] mem_rdata
);
  logic [7:0] ram [0:255];
  logic wait_done = 1'b0;
  logic [7:0] last = 8'h00;
  // A slow answer inserts one wait cycle; idle read data is scrambled so it cannot pass for valid.
  assign mem_ready = mem.req && (!slow || wait_done);
  assign mem_rdata = mem_ready ? ram[mem.addr[7:0]] : ~last;
  always @(posedge ref_clk) begin
    wait_done <= mem.req && !mem_ready;
    if (mem_ready) begin
      last <= mem_rdata;
      if (mem.wr) begin
        ram[mem.addr[7:0]] <= mem.wdata;
      end
    end
  end
endmodule

// ---- sim/string_ops_checker.sv ----
// Concurrent checks on the string engine's ports.
`timescale 1ns/1ps
module string_ops_checker (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic start,
  input wire string_ops_pkg::op_t op,
  input wire logic descend,
  input wire logic break_req,
  input wire string_ops_pkg::mem_req_t mem,
  input wire logic busy,
  input wire logic done,
  input wire logic break_ack,
  input wire string_ops_pkg::regs_t regs_out,
  input wire string_ops_pkg::flags_t flags_out
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  done_pulse_a: assert property (done |=> !done) else $error("done longer than one cycle");
  ack_cause_a: assert property (break_ack |-> $past(break_req) && !done ##1 !break_ack)
    else $error("suspend without request");
  start_busy_a: assert property (start && !busy |=> busy) else $error("start not taken");
  fill_write_a: assert property (busy && op == string_ops_pkg::fill_block_op && mem.req |->
    mem.wr && mem.wdata == regs_out.accum && mem.addr == regs_out.target_pointer) else $error("bad fill write");
  scan_nowrite_a: assert property (busy && $past(busy) && op == string_ops_pkg::scan_equal_op |->
    !(mem.req && mem.wr) && $stable(regs_out.accum)) else $error("scan modified data");
  flags_hold_a: assert property (busy && $past(busy) && op != string_ops_pkg::scan_equal_op |->
    $stable(flags_out)) else $error("flags changed");
  count_step_a: assert property (busy && $past(busy) && $changed(regs_out.count) |->
    regs_out.count == $past(regs_out.count) - 8'h01) else $error("count step wrong");
  pointer_step_a: assert property (busy && $past(busy) && $changed(regs_out.target_pointer) |->
    regs_out.target_pointer == ($past(descend) ? $past(regs_out.target_pointer) - 16'h0001
    : $past(regs_out.target_pointer) + 16'h0001)) else $error("pointer step wrong");
  cover property (done && op == string_ops_pkg::scan_equal_op);
  cover property (break_ack);
  cover property (done && op == string_ops_pkg::swap_block_op);
endmodule
bind block_string_ops string_ops_checker chk (.ref_clk, .rst_b, .start, .op, .descend, .break_req, .mem, .busy,
  .done, .break_ack, .regs_out, .flags_out);

// ---- sim/tb_top.sv ----
// Self-checking bench for the string engine.
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin check_count++; if ((got) !== (exp)) begin err_total++; \
  $display("wrong value %s expected %h seen %h", nm, exp, got); end end
module tb_top;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic start = 1'b0;
  string_ops_pkg::op_t op = string_ops_pkg::fill_block_op;
  logic descend = 1'b0;
  string_ops_pkg::regs_t regs_in = '0;
  string_ops_pkg::flags_t flags_in = '0;
  logic break_req = 1'b0;
  logic slow = 1'b0;
  logic mem_ready;
  logic [7:0] mem_rdata;
  string_ops_pkg::mem_req_t mem;
  logic busy;
  logic done;
  logic break_ack;
  string_ops_pkg::regs_t regs_out;
  string_ops_pkg::flags_t flags_out;
  int err_total = 0;
  int check_count = 0;
  logic last_break = 1'b0;
  always #50 ref_clk = ~ref_clk;
  block_string_ops dut (.ref_clk, .rst_b, .start, .op, .descend, .regs_in, .flags_in, .break_req, .mem_ready,
    .mem_rdata, .mem, .busy, .done, .break_ack, .regs_out, .flags_out);
  mem_model m (.ref_clk, .slow, .mem, .mem_ready, .mem_rdata);
  task automatic tick;
    @(posedge ref_clk);
    #1;
  endtask
  task automatic finish_test;
    $display("checks %0d errors %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic run(input string_ops_pkg::op_t o, input logic d, input string_ops_pkg::regs_t r, input logic brk);
    int n;
    op = o;
    descend = d;
    regs_in = r;
    break_req = brk;
    start = 1'b1;
    tick;
    start = 1'b0;
    n = 0;
    while (done !== 1'b1 && break_ack !== 1'b1) begin
      tick;
      n++;
      if (n > 3000) begin
        err_total++;
        finish_test;
      end
    end
    last_break = (break_ack === 1'b1);
    break_req = 1'b0;
    tick;
  endtask
  task automatic t_full_range;
    flags_in = 5'h15;
    run(string_ops_pkg::fill_block_op, 1'b0, {16'h0000, 16'h0000, 8'h00, 8'h3C}, 1'b0);
    `CHK("fill last", 8'h3C, m.ram[255])
    `CHK("fill first", 8'h3C, m.ram[0])
    `CHK("fill count", 8'h00, regs_out.count)
    `CHK("fill ptr", 16'h0100, regs_out.target_pointer)
    `CHK("fill flags", 5'h15, flags_out)
    `CHK("fill no suspend", 1'b0, last_break)
    flags_in = 5'h00;
    run(string_ops_pkg::scan_equal_op, 1'b0, {16'h0000, 16'h0000, 8'h00, 8'h3C}, 1'b0);
    `CHK("scan ptr", 16'h0100, regs_out.target_pointer)
    `CHK("scan flags", 5'h08, flags_out)
  endtask
  task automatic t_suspend;
    run(string_ops_pkg::fill_block_op, 1'b0, {16'h0090, 16'h0000, 8'h04, 8'h5A}, 1'b1);
    `CHK("ack", 1'b1, last_break)
    `CHK("held count", 8'h03, regs_out.count)
    `CHK("first byte", 8'h5A, m.ram[8'h90])
    `CHK("not yet", 8'h3C, m.ram[8'h93])
    flags_in = flags_out;
    run(string_ops_pkg::fill_block_op, 1'b0, regs_out, 1'b0);
    `CHK("resumed", 8'h5A, m.ram[8'h93])
    `CHK("past end", 8'h3C, m.ram[8'h94])
    `CHK("end ptr", 16'h0094, regs_out.target_pointer)
    run(string_ops_pkg::fill_block_op, 1'b0, {16'h00D0, 16'h0000, 8'h01, 8'h77}, 1'b1);
    `CHK("last byte wins", 1'b0, last_break)
    `CHK("last byte", 8'h77, m.ram[8'hD0])
  endtask
  task automatic t_moves;
    slow = 1'b1;
    m.ram[8'h41] = 8'hC1;
    m.ram[8'h40] = 8'hC0;
    run(string_ops_pkg::copy_block_op, 1'b1, {16'h0031, 16'h0041, 8'h02, 8'h00}, 1'b0);
    slow = 1'b0;
    `CHK("copy hi", 8'hC1, m.ram[8'h31])
    `CHK("copy lo", 8'hC0, m.ram[8'h30])
    `CHK("copy src", 16'h003F, regs_out.source_pointer)
    m.ram[8'h50] = 8'h11;
    m.ram[8'h51] = 8'h22;
    run(string_ops_pkg::swap_accum_mem_op, 1'b0, {16'h0050, 16'h0000, 8'h02, 8'h99}, 1'b0);
    `CHK("xa mem", 16'h9911, {m.ram[8'h50], m.ram[8'h51]})
    `CHK("xa acc", 8'h22, regs_out.accum)
    m.ram[8'h60] = 8'hAA;
    m.ram[8'h70] = 8'hBB;
    run(string_ops_pkg::swap_block_op, 1'b1, {16'h0060, 16'h0070, 8'h01, 8'h00}, 1'b0);
    `CHK("xb mem", 16'hBBAA, {m.ram[8'h60], m.ram[8'h70]})
    `CHK("xb ptrs", 32'h005F006F, {regs_out.target_pointer, regs_out.source_pointer})
  endtask
  task automatic t_overlap;
    m.ram[8'hA1] = 8'h01;
    m.ram[8'hA2] = 8'h02;
    m.ram[8'hA3] = 8'h03;
    run(string_ops_pkg::copy_block_op, 1'b0, {16'h00A0, 16'h00A1, 8'h03, 8'h00}, 1'b0);
    `CHK("up overlap", 24'h010203, {m.ram[8'hA0], m.ram[8'hA1], m.ram[8'hA2]})
    `CHK("up ptrs", 32'h00A300A4, {regs_out.target_pointer, regs_out.source_pointer})
    m.ram[8'hB0] = 8'h04;
    m.ram[8'hB1] = 8'h05;
    m.ram[8'hB2] = 8'h06;
    run(string_ops_pkg::copy_block_op, 1'b1, {16'h00B3, 16'h00B2, 8'h03, 8'h00}, 1'b0);
    `CHK("down overlap", 24'h040506, {m.ram[8'hB1], m.ram[8'hB2], m.ram[8'hB3]})
    `CHK("down ptrs", 32'h00B000AF, {regs_out.target_pointer, regs_out.source_pointer})
    m.ram[8'hC0] = 8'h0A;
    m.ram[8'hC1] = 8'h0B;
    m.ram[8'hC2] = 8'h0C;
    run(string_ops_pkg::swap_accum_mem_op, 1'b1, {16'h00C2, 16'h0000, 8'h03, 8'h00}, 1'b0);
    `CHK("shift down", 24'h0B0C00, {m.ram[8'hC0], m.ram[8'hC1], m.ram[8'hC2]})
    `CHK("shift acc", 8'h0A, regs_out.accum)
    `CHK("shift ptr", 16'h00BF, regs_out.target_pointer)
  endtask
  task automatic t_scan_stop;
    m.ram[8'h80] = 8'h07;
    m.ram[8'h81] = 8'h07;
    m.ram[8'h82] = 8'h03;
    m.ram[8'h84] = 8'h80;
    run(string_ops_pkg::scan_equal_op, 1'b0, {16'h0080, 16'h0000, 8'h04, 8'h07}, 1'b0);
    `CHK("stop ptr", 16'h0083, regs_out.target_pointer)
    `CHK("stop count", 8'h01, regs_out.count)
    `CHK("untouched", 16'h0307, {m.ram[8'h82], regs_out.accum})
    `CHK("flags 03-07", 5'h15, flags_out)
    run(string_ops_pkg::scan_equal_op, 1'b0, {16'h0084, 16'h0000, 8'h01, 8'h01}, 1'b0);
    `CHK("flags 80-01", 5'h06, flags_out)
  endtask
  initial begin
    repeat (10) tick;
    rst_b = 1'b1;
    t_full_range;
    t_suspend;
    t_moves;
    t_overlap;
    t_scan_stop;
    finish_test;
  end
endmodule
